/* shared/pmc_defines.vh */
// constants for the paging mode control checker
//------------------------------------------------------------------
// Functional notes
//------------------------------------------------------------------
`ifndef PMC_DEFINES_VH
`define PMC_DEFINES_VH
//------------------------------------------------------------------
// control bit positions
//------------------------------------------------------------------
`define PMC_C0_WGUARD   16
`define PMC_C0_PAGING   31
`define PMC_C4_BIGPG    4
`define PMC_C4_WIDE     5
`define PMC_C4_GLOBAL   7
`define PMC_C4_CTXID    17
`define PMC_C4_FGUARD   20
`define PMC_EF_LMEN     8
`define PMC_EF_LMACT    10
`define PMC_EF_NOEX     11
//------------------------------------------------------------------
// feature query bit positions
//------------------------------------------------------------------
`define PMC_L1D_BIGPG   3
`define PMC_L1D_WIDE    6
`define PMC_L1D_GLOBAL  13
`define PMC_L1D_BIG40   17
`define PMC_L1C_CTXID   17
`define PMC_L7B_FGUARD  7
`define PMC_X1D_XDIS    20
`define PMC_X1D_GIG     26
`define PMC_X1D_LMOD    29
//------------------------------------------------------------------
// leaf codes and widths
//------------------------------------------------------------------
`define PMC_LEAF_01     32'h0000_0001
`define PMC_LEAF_07     32'h0000_0007
`define PMC_LEAF_X1     32'h8000_0001
`define PMC_LEAF_X8     32'h8000_0008
`define PMC_PHYS_MAX    8'h34
`define PMC_PHYS_WIDE   8'h24
`define PMC_WIDTH_32    8'h20
`define PMC_LIN_LONG    8'h30
`define PMC_PHYS_BIG40  8'h28
//------------------------------------------------------------------
// paging mode codes (one-hot)
//------------------------------------------------------------------
`define PMC_MODE_NONE   4'h1
`define PMC_MODE_LEGACY 4'h2
`define PMC_MODE_WIDE   4'h4
`define PMC_MODE_LONG   4'h8
//------------------------------------------------------------------
// write targets
//------------------------------------------------------------------
`define PMC_TGT_C0      2'h0
`define PMC_TGT_C4      2'h1
`define PMC_TGT_EF      2'h2
//------------------------------------------------------------------
// reset values
//------------------------------------------------------------------
`define PMC_RST_C0      32'h0000_0000
`define PMC_RST_C4      32'h0000_0000
`define PMC_RST_EF      32'h0000_0000
`endif

/* verilog/pmc_checker.v */
// paging mode control checker: control registers, mode and feature query
`include "pmc_defines.vh"

module pmc_checker #(
  parameter HAS_LEAF_X1 = 1'b1,  // extended leaf 80000001H present
  parameter HAS_LEAF_X8 = 1'b1,  // extended leaf 80000008H present
  parameter [7:0] PHYS_W = 8'h2e,  // reported physical width, at most 52
  parameter SUP_BIGPG  = 1'b1,
  parameter SUP_WIDE   = 1'b1,
  parameter SUP_GLOBAL = 1'b1,
  parameter SUP_BIG40  = 1'b1,
  parameter SUP_CTXID  = 1'b1,
  parameter SUP_FGUARD = 1'b1,
  parameter SUP_XDIS   = 1'b1,
  parameter SUP_GIG    = 1'b1,
  parameter SUP_LMOD   = 1'b1
) (
  input  wire        clk,
  input  wire        rstn,
  input  wire        wr_req,         // single register write
  input  wire [1:0]  wr_target,      // 0 sys_ctl_zero, 1 sys_ctl_four, 2 ext_feature_msr
  input  wire [31:0] wr_data,
  input  wire        vt_load,        // virt transition: load all three
  input  wire [31:0] vt_ctl_zero,
  input  wire [31:0] vt_ctl_four,
  input  wire [31:0] vt_ext_feat,
  input  wire [31:0] fq_leaf,        // feature query leaf
  input  wire [31:0] fq_subleaf,
  input  wire        chk_req,        // access check request
  input  wire [63:0] chk_lin_addr,
  input  wire        chk_64bit,      // core in 64-bit sub-mode
  input  wire        chk_write,
  input  wire        chk_fetch,
  input  wire        chk_user_lvl,   // privilege_level is 3
  input  wire        pg_read_only,
  input  wire        pg_user_ok,     // page accessible at user level
  input  wire        pg_xd,          // entry marks execute-disable
  input  wire        pg_global,      // entry marks global
  input  wire        pg_big,         // entry maps a large page
  output reg  [31:0] sys_ctl_zero_ff,
  output reg  [31:0] sys_ctl_four_ff,
  output reg  [31:0] ext_feature_msr_ff,
  output reg  [3:0]  mode_ff,        // one-hot paging mode
  output reg         wr_fault_ff,    // protection_fault, code zero
  output reg         wr_done_ff,     // write accepted
  output reg  [31:0] fq_eax_ff,
  output reg  [31:0] fq_ebx_ff,
  output reg  [31:0] fq_ecx_ff,
  output reg  [31:0] fq_edx_ff,
  output reg         chk_fault_ff,   // protection_fault for non-canonical
  output reg         chk_deny_ff,    // access right refused
  output reg         chk_share_ff,   // translation may be shared
  output reg         chk_big_ok_ff,  // large page mapping allowed
  output reg  [7:0]  chk_phys_w_ff   // physical width for this translation
);

  //------------------------------------------------------------------
  // current bits
  //------------------------------------------------------------------
  wire paging_on     = sys_ctl_zero_ff[`PMC_C0_PAGING];
  wire write_guard   = sys_ctl_zero_ff[`PMC_C0_WGUARD];
  wire wide_entry_en = sys_ctl_four_ff[`PMC_C4_WIDE];
  wire big_page_en   = sys_ctl_four_ff[`PMC_C4_BIGPG];
  wire global_pg_en  = sys_ctl_four_ff[`PMC_C4_GLOBAL];
  wire context_id_en = sys_ctl_four_ff[`PMC_C4_CTXID];
  wire fetch_guard   = sys_ctl_four_ff[`PMC_C4_FGUARD];
  wire long_mode_en  = ext_feature_msr_ff[`PMC_EF_LMEN];
  wire no_execute_en = ext_feature_msr_ff[`PMC_EF_NOEX];
  wire lmod_act      = paging_on & long_mode_en;  // long_mode_paging in force

  // feature gates; a missing leaf 80000001H refuses execute-disable and long mode
  wire has_xdis = HAS_LEAF_X1 & SUP_XDIS;
  wire has_lmod = HAS_LEAF_X1 & SUP_LMOD;

  //------------------------------------------------------------------
  // proposed values for a single write
  //------------------------------------------------------------------
  reg [31:0] p_c0;
  reg [31:0] p_c4;
  reg [31:0] p_ef;
  reg        bad;
  // forms the proposed values and decides whether the write faults; nothing is stored here
  always @* begin
    p_c0 = sys_ctl_zero_ff;
    p_c4 = sys_ctl_four_ff;
    p_ef = ext_feature_msr_ff;
    bad  = 1'b0;
    case (wr_target)
      `PMC_TGT_C0: begin
        p_c0 = wr_data;
        // enabling paging with long mode but no wide entries
        if (!paging_on && wr_data[`PMC_C0_PAGING] && !wide_entry_en && long_mode_en)
          bad = 1'b1;
        // clearing paging with context ids on; otherwise allowed
        if (paging_on && !wr_data[`PMC_C0_PAGING] && context_id_en)
          bad = 1'b1;
      end
      `PMC_TGT_C4: begin
        p_c4 = wr_data;
        if (lmod_act && !wr_data[`PMC_C4_WIDE])
          bad = 1'b1;
        // context ids only under long-mode paging
        if (wr_data[`PMC_C4_CTXID] && !lmod_act)
          bad = 1'b1;
        // unsupported enables refused
        if ((wr_data[`PMC_C4_BIGPG] && !SUP_BIGPG) || (wr_data[`PMC_C4_WIDE] && !SUP_WIDE) ||
            (wr_data[`PMC_C4_GLOBAL] && !SUP_GLOBAL))
          bad = 1'b1;
        if ((wr_data[`PMC_C4_CTXID] && !SUP_CTXID) || (wr_data[`PMC_C4_FGUARD] && !SUP_FGUARD))
          bad = 1'b1;
        // toggling wide entries under paging outside long mode switches mode directly
      end
      `PMC_TGT_EF: begin
        p_ef = wr_data;
        // status bit is not writable; it is recomputed from the new state
        p_ef[`PMC_EF_LMACT] = ext_feature_msr_ff[`PMC_EF_LMACT];
        if (paging_on && (wr_data[`PMC_EF_LMEN] != long_mode_en))
          bad = 1'b1;
        if (wr_data[`PMC_EF_NOEX] && !has_xdis)
          bad = 1'b1;
        if (wr_data[`PMC_EF_LMEN] && !has_lmod)
          bad = 1'b1;
      end
      default: bad = 1'b1;  // unknown target refused
    endcase
  end

  //------------------------------------------------------------------
  // mode from a register triple
  //------------------------------------------------------------------
  // one-hot mode code from paging_on, wide_entry_en and long_mode_en
  function [3:0] mode_of;
    input pon;
    input wen;
    input lmen;
    begin
      if (!pon)
        mode_of = `PMC_MODE_NONE;
      else if (!wen)
        mode_of = `PMC_MODE_LEGACY;
      else if (!lmen)
        mode_of = `PMC_MODE_WIDE;
      else
        mode_of = `PMC_MODE_LONG;
    end
  endfunction

  //------------------------------------------------------------------
  // register update; virt transition has priority and is atomic
  //------------------------------------------------------------------
  reg [31:0] nxt_c0;
  reg [31:0] nxt_c4;
  reg [31:0] nxt_ef;
  reg        nxt_fault;
  reg        nxt_done;
  // next register state; a refused write leaves all of it untouched
  always @* begin
    nxt_c0    = sys_ctl_zero_ff;
    nxt_c4    = sys_ctl_four_ff;
    nxt_ef    = ext_feature_msr_ff;
    nxt_fault = 1'b0;
    nxt_done  = 1'b0;
    // a load is trusted and skips every write check, so it can reach
    // mode changes that single writes are refused
    if (vt_load) begin
      nxt_c0   = vt_ctl_zero;
      nxt_c4   = vt_ctl_four;
      nxt_ef   = vt_ext_feat;
      nxt_done = 1'b1;
    end else if (wr_req) begin
      if (bad) begin
        nxt_fault = 1'b1;
      end else begin
        nxt_c0   = p_c0;
        nxt_c4   = p_c4;
        nxt_ef   = p_ef;
        nxt_done = 1'b1;
      end
    end
    // status bit always mirrors the new state
    nxt_ef[`PMC_EF_LMACT] = nxt_c0[`PMC_C0_PAGING] & nxt_ef[`PMC_EF_LMEN];
  end

  // control registers, mode and the one-cycle write pulses
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sys_ctl_zero_ff    <= `PMC_RST_C0;
      sys_ctl_four_ff    <= `PMC_RST_C4;
      ext_feature_msr_ff <= `PMC_RST_EF;
      mode_ff            <= `PMC_MODE_NONE;
      wr_fault_ff        <= 1'b0;
      wr_done_ff         <= 1'b0;
    end else begin
      sys_ctl_zero_ff    <= nxt_c0;
      sys_ctl_four_ff    <= nxt_c4;
      ext_feature_msr_ff <= nxt_ef;
      mode_ff            <= mode_of(nxt_c0[`PMC_C0_PAGING], nxt_c4[`PMC_C4_WIDE],
                                    nxt_ef[`PMC_EF_LMEN]);
      wr_fault_ff        <= nxt_fault;
      wr_done_ff         <= nxt_done;
    end
  end

  //------------------------------------------------------------------
  // feature query answer, one cycle
  //------------------------------------------------------------------
  reg [31:0] nxt_eax;
  reg [31:0] nxt_ebx;
  reg [31:0] nxt_ecx;
  reg [31:0] nxt_edx;
  // answer depends on the leaf and subleaf only, so it stands while both are held
  always @* begin
    nxt_eax = 32'h0000_0000;
    nxt_ebx = 32'h0000_0000;
    nxt_ecx = 32'h0000_0000;
    nxt_edx = 32'h0000_0000;
    case (fq_leaf)
      `PMC_LEAF_01: begin
        nxt_edx[`PMC_L1D_BIGPG]  = SUP_BIGPG;
        nxt_edx[`PMC_L1D_WIDE]   = SUP_WIDE;
        nxt_edx[`PMC_L1D_GLOBAL] = SUP_GLOBAL;
        nxt_edx[`PMC_L1D_BIG40]  = SUP_BIG40;
        nxt_ecx[`PMC_L1C_CTXID]  = SUP_CTXID;
      end
      `PMC_LEAF_07: begin
        if (fq_subleaf == 32'h0000_0000)
          nxt_ebx[`PMC_L7B_FGUARD] = SUP_FGUARD;
      end
      `PMC_LEAF_X1: begin
        if (HAS_LEAF_X1) begin
          nxt_edx[`PMC_X1D_XDIS] = SUP_XDIS;
          nxt_edx[`PMC_X1D_GIG]  = SUP_GIG;
          nxt_edx[`PMC_X1D_LMOD] = SUP_LMOD;
        end
      end
      `PMC_LEAF_X8: begin
        if (HAS_LEAF_X8) begin
          nxt_eax[7:0]  = (PHYS_W > `PMC_PHYS_MAX) ? `PMC_PHYS_MAX : PHYS_W;
          nxt_eax[15:8] = has_lmod ? `PMC_LIN_LONG : `PMC_WIDTH_32;
        end
      end
      default: nxt_eax = 32'h0000_0000;  // unknown leaf reads zero
    endcase
  end

  // physical width used by translations
  wire [7:0] phys_w = HAS_LEAF_X8 ? ((PHYS_W > `PMC_PHYS_MAX) ? `PMC_PHYS_MAX : PHYS_W) :
                      (SUP_WIDE ? `PMC_PHYS_WIDE : `PMC_WIDTH_32);

  //------------------------------------------------------------------
  // access check against the modifiers
  //------------------------------------------------------------------
  // checks use the registered mode, so a write and a check never race
  wire in_legacy = mode_ff[1];
  wire xdis_live = no_execute_en & (mode_ff[2] | mode_ff[3]);
  // bits 63:47 all equal
  wire canon     = (&chk_lin_addr[63:47]) | ~(|chk_lin_addr[63:47]);
  wire noncanon  = chk_req & chk_64bit & mode_ff[3] & ~canon;
  reg        nxt_deny;
  reg  [7:0] nxt_pw;
  // rights are judged only with paging on and no non-canonical fault; an
  // address faulted as non-canonical still gets share, big page and width results
  always @* begin
    nxt_deny = 1'b0;
    nxt_pw   = in_legacy ? `PMC_WIDTH_32 : phys_w;
    if (chk_req && paging_on && !noncanon) begin
      if (chk_write && pg_read_only && (chk_user_lvl || write_guard))
        nxt_deny = 1'b1;
      if (chk_fetch && !chk_user_lvl && fetch_guard && pg_user_ok)
        nxt_deny = 1'b1;
      if (chk_fetch && pg_xd && xdis_live)
        nxt_deny = 1'b1;
      if (in_legacy && pg_big && big_page_en && SUP_BIG40)
        nxt_pw = `PMC_PHYS_BIG40;
    end
  end

  // query answer and check results, each one cycle after its input
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fq_eax_ff     <= 32'h0000_0000;
      fq_ebx_ff     <= 32'h0000_0000;
      fq_ecx_ff     <= 32'h0000_0000;
      fq_edx_ff     <= 32'h0000_0000;
      chk_fault_ff  <= 1'b0;
      chk_deny_ff   <= 1'b0;
      chk_share_ff  <= 1'b0;
      chk_big_ok_ff <= 1'b0;
      chk_phys_w_ff <= `PMC_WIDTH_32;
    end else begin
      fq_eax_ff     <= nxt_eax;
      fq_ebx_ff     <= nxt_ebx;
      fq_ecx_ff     <= nxt_ecx;
      fq_edx_ff     <= nxt_edx;
      chk_fault_ff  <= noncanon;
      chk_deny_ff   <= nxt_deny;
      chk_share_ff  <= chk_req & paging_on & global_pg_en & pg_global;
      // legacy big pages need the enable; wide and long modes always may
      chk_big_ok_ff <= chk_req & paging_on & (in_legacy ? big_page_en : 1'b1);
      chk_phys_w_ff <= nxt_pw;
    end
  end

endmodule // pmc_checker

/* bench/pmc_checker_props.sv */
// port assertions for the paging mode control checker
module pmc_props (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        wr_req,
  input wire logic [1:0]  wr_target,
  input wire logic [31:0] wr_data,
  input wire logic        vt_load,
  input wire logic [31:0] vt_ctl_zero,
  input wire logic [31:0] vt_ctl_four,
  input wire logic [31:0] vt_ext_feat,
  input wire logic        chk_req,
  input wire logic [63:0] chk_lin_addr,
  input wire logic        chk_64bit,
  input wire logic [31:0] sys_ctl_zero_ff,
  input wire logic [31:0] sys_ctl_four_ff,
  input wire logic [31:0] ext_feature_msr_ff,
  input wire logic [3:0]  mode_ff,
  input wire logic        wr_fault_ff,
  input wire logic        wr_done_ff,
  input wire logic        chk_fault_ff
);
  timeunit 1ns;
  timeprecision 100ps;
  // -----------------------------------------------------------
  // shorthands
  // -----------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  wire sw   = wr_req & ~vt_load;        // single write, not shadowed by a load
  wire pon  = sys_ctl_zero_ff[31];      // paging_on
  wire wd   = sys_ctl_four_ff[5];       // wide_entry_en
  wire lmen = ext_feature_msr_ff[8];    // long_mode_en
  property p_lma; ext_feature_msr_ff[10] == (pon & lmen); endproperty
  a_lma: assert property (p_lma) else $error("active flag wrong");
  property p_mode; mode_ff == (!pon ? 4'h1 : !wd ? 4'h2 : !lmen ? 4'h4 : 4'h8); endproperty
  a_mode: assert property (p_mode) else $error("mode wrong");
  property p_lmchg; sw && wr_target == 2'h2 && pon && wr_data[8] != lmen |=> wr_fault_ff;
  endproperty
  a_lmchg: assert property (p_lmchg) else $error("long enable change kept");
  property p_pgon; sw && wr_target == 2'h0 && wr_data[31] && !wd && lmen |=> wr_fault_ff;
  endproperty
  a_pgon: assert property (p_pgon) else $error("paging on without wide kept");
  property p_wide; sw && wr_target == 2'h1 && pon && lmen && !wr_data[5] |=> wr_fault_ff;
  endproperty
  a_wide: assert property (p_wide) else $error("wide clear kept");
  property p_ctx; sw && wr_target == 2'h0 && sys_ctl_four_ff[17] && !wr_data[31] |=> wr_fault_ff;
  endproperty
  a_ctx: assert property (p_ctx) else $error("paging off with context ids kept");
  property p_clr; sw && wr_target == 2'h0 && pon && !wr_data[31] && !sys_ctl_four_ff[17]
    |=> wr_done_ff && !sys_ctl_zero_ff[31]; endproperty
  a_clr: assert property (p_clr) else $error("paging off refused");
  property p_hold; wr_fault_ff |-> $stable(sys_ctl_zero_ff) && $stable(sys_ctl_four_ff)
    && $stable(ext_feature_msr_ff) && $stable(mode_ff); endproperty
  a_hold: assert property (p_hold) else $error("state moved on fault");
  property p_vt; vt_load |=> sys_ctl_zero_ff == $past(vt_ctl_zero)
    && sys_ctl_four_ff == $past(vt_ctl_four) && lmen == $past(vt_ext_feat[8]); endproperty
  a_vt: assert property (p_vt) else $error("load not atomic");
  property p_canon; chk_req && mode_ff == 4'h8 && chk_64bit && chk_lin_addr[63:47] != 17'h0
    && chk_lin_addr[63:47] != 17'h1_ffff |=> chk_fault_ff; endproperty
  a_canon: assert property (p_canon) else $error("non-canonical passed");
endmodule // pmc_props

bind pmc_checker pmc_props u_props (.clk(clk), .rstn(rstn), .wr_req(wr_req),
  .wr_target(wr_target), .wr_data(wr_data), .vt_load(vt_load), .vt_ctl_zero(vt_ctl_zero),
  .vt_ctl_four(vt_ctl_four), .vt_ext_feat(vt_ext_feat), .chk_req(chk_req),
  .chk_lin_addr(chk_lin_addr), .chk_64bit(chk_64bit), .sys_ctl_zero_ff(sys_ctl_zero_ff),
  .sys_ctl_four_ff(sys_ctl_four_ff), .ext_feature_msr_ff(ext_feature_msr_ff),
  .mode_ff(mode_ff), .wr_fault_ff(wr_fault_ff), .wr_done_ff(wr_done_ff),
  .chk_fault_ff(chk_fault_ff));

/* bench/pmc_testbench.sv */
// self-checking bench for the paging mode control checker
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] PHYS = 8'h2e;  // width reported by the extended leaf
  logic        clk = 0, rstn = 0, wr_req = 0, vt_load = 0, chk_req = 0, chk_64bit = 0;
  logic        chk_write = 0, chk_fetch = 0, chk_user_lvl = 0, pg_read_only = 0;
  logic        pg_user_ok = 0, pg_xd = 0, pg_global = 0, pg_big = 0;
  logic        wr_fault_ff, wr_done_ff, chk_fault_ff, chk_deny_ff, chk_share_ff, chk_big_ok_ff;
  logic [1:0]  wr_target = 0;
  logic [3:0]  mode_ff;
  logic [7:0]  chk_phys_w_ff;
  logic [31:0] wr_data = 0, vt_ctl_zero = 0, vt_ctl_four = 0, vt_ext_feat = 0, fq_leaf = 0;
  logic [31:0] fq_subleaf = 0, sys_ctl_zero_ff, sys_ctl_four_ff, ext_feature_msr_ff;
  logic [31:0] fq_eax_ff, fq_ebx_ff, fq_ecx_ff, fq_edx_ff;
  logic [63:0] chk_lin_addr = 0;
  int          err_count = 0, comparisons = 0;
  // design under test, every port driven or watched
  pmc_checker #(.PHYS_W(PHYS)) dut (.clk(clk), .rstn(rstn), .wr_req(wr_req),
    .wr_target(wr_target), .wr_data(wr_data), .vt_load(vt_load), .vt_ctl_zero(vt_ctl_zero),
    .vt_ctl_four(vt_ctl_four), .vt_ext_feat(vt_ext_feat), .fq_leaf(fq_leaf),
    .fq_subleaf(fq_subleaf), .chk_req(chk_req), .chk_lin_addr(chk_lin_addr),
    .chk_64bit(chk_64bit), .chk_write(chk_write), .chk_fetch(chk_fetch),
    .chk_user_lvl(chk_user_lvl), .pg_read_only(pg_read_only), .pg_user_ok(pg_user_ok),
    .pg_xd(pg_xd), .pg_global(pg_global), .pg_big(pg_big), .sys_ctl_zero_ff(sys_ctl_zero_ff),
    .sys_ctl_four_ff(sys_ctl_four_ff), .ext_feature_msr_ff(ext_feature_msr_ff),
    .mode_ff(mode_ff), .wr_fault_ff(wr_fault_ff), .wr_done_ff(wr_done_ff),
    .fq_eax_ff(fq_eax_ff), .fq_ebx_ff(fq_ebx_ff), .fq_ecx_ff(fq_ecx_ff), .fq_edx_ff(fq_edx_ff),
    .chk_fault_ff(chk_fault_ff), .chk_deny_ff(chk_deny_ff), .chk_share_ff(chk_share_ff),
    .chk_big_ok_ff(chk_big_ok_ff), .chk_phys_w_ff(chk_phys_w_ff));
  // -----------------------------------------------------------
  // shared drivers; inputs move on the falling edge only
  // -----------------------------------------------------------
  always #5 clk = ~clk;
  task automatic cmp(input string nm, input logic [63:0] exp, input logic [63:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one write, pulse held a full cycle, answer read in its standing cycle
  task automatic wr(input logic [1:0] tg, input logic [31:0] d, input logic flt);
    @(negedge clk);
    wr_target = tg;
    wr_data = d;
    wr_req = 1;
    @(negedge clk);
    wr_req = 0;
    cmp("wr_fault", flt, wr_fault_ff);
    cmp("wr_done", !flt, wr_done_ff);
  endtask
  // atomic load of all three registers
  task automatic vt(input logic [31:0] z, input logic [31:0] f, input logic [31:0] e);
    @(negedge clk);
    vt_ctl_zero = z;
    vt_ctl_four = f;
    vt_ext_feat = e;
    vt_load = 1;
    @(negedge clk);
    vt_load = 0;
    cmp("vt_done", 1, wr_done_ff);
  endtask
  // access check; deny only judged when no fault is due
  task automatic ck(input logic [63:0] a, input logic w, u, ro, ef, dn);
    @(negedge clk);
    chk_lin_addr = a;
    chk_write = w;
    chk_user_lvl = u;
    pg_user_ok = u;
    pg_read_only = ro;
    chk_req = 1;
    @(negedge clk);
    chk_req = 0;
    cmp("chk_fault", ef, chk_fault_ff);
    if (!ef) cmp("chk_deny", dn, chk_deny_ff);
  endtask
  // supervisor fetch check with entry marks; deny, share, big page and width read in their standing cycle
  task automatic ckx(input logic uo, xd, gl, bg, dn, sh, bo, input logic [7:0] pw);
    @(negedge clk);
    chk_lin_addr = 0;
    chk_write = 0;
    chk_user_lvl = 0;
    pg_read_only = 0;
    chk_fetch = 1;
    pg_user_ok = uo;
    pg_xd = xd;
    pg_global = gl;
    pg_big = bg;
    chk_req = 1;
    @(negedge clk);
    chk_req = 0;
    chk_fetch = 0;
    cmp("chk_deny", dn, chk_deny_ff);
    cmp("chk_share", sh, chk_share_ff);
    cmp("chk_big_ok", bo, chk_big_ok_ff);
    cmp("chk_phys_w", pw, chk_phys_w_ff);
  endtask
  // query a leaf, mask the reported field
  task automatic fq(input logic [31:0] lf, input int rg, input logic [31:0] m, e);
    @(negedge clk);
    fq_leaf = lf;
    @(negedge clk);
    cmp("fq", e, m & (rg == 0 ? fq_eax_ff : rg == 1 ? fq_ebx_ff : rg == 2 ? fq_ecx_ff
                      : fq_edx_ff));
  endtask
  // -----------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------
  task automatic t_modes;
    cmp("mode", 4'h1, mode_ff);
    cmp("phys_w", 8'h20, chk_phys_w_ff);
    wr(2'h0, 32'h8000_0000, 0);
    cmp("mode", 4'h2, mode_ff);
    wr(2'h1, 32'h0000_0020, 0);
    cmp("mode", 4'h4, mode_ff);
    wr(2'h1, 32'h0000_0000, 0);
    cmp("mode", 4'h2, mode_ff);
    wr(2'h2, 32'h0000_0100, 1);
    cmp("ext", 32'h0000_0000, ext_feature_msr_ff);
    wr(2'h1, 32'h0002_0000, 1);
    wr(2'h0, 32'h0000_0000, 0);
    cmp("mode", 4'h1, mode_ff);
  endtask
  task automatic t_long;
    wr(2'h2, 32'h0000_0100, 0);
    wr(2'h0, 32'h8000_0000, 1);
    cmp("mode", 4'h1, mode_ff);
    wr(2'h1, 32'h0000_0020, 0);
    wr(2'h0, 32'h8000_0000, 0);
    cmp("mode", 4'h8, mode_ff);
    cmp("ext", 32'h0000_0500, ext_feature_msr_ff);
    wr(2'h1, 32'h0000_0000, 1);
    cmp("four", 32'h0000_0020, sys_ctl_four_ff);
    wr(2'h1, 32'h0002_0020, 0);
    wr(2'h0, 32'h0000_0000, 1);
    wr(2'h1, 32'h0000_0020, 0);
    wr(2'h0, 32'h0000_0000, 0);
    cmp("ext", 32'h0000_0100, ext_feature_msr_ff);
  endtask
  // direct long to legacy hop, only reachable by a load
  task automatic t_vt;
    chk_64bit = 1;
    vt(32'h8000_0000, 32'h0000_0020, 32'h0000_0100);
    cmp("mode", 4'h8, mode_ff);
    ck(64'h0000_8000_0000_0000, 0, 0, 0, 1, 0);
    ck(64'hffff_8000_0000_0000, 0, 0, 0, 0, 0);
    vt(32'h8000_0000, 32'h0000_0000, 32'h0000_0000);
    cmp("mode", 4'h2, mode_ff);
  endtask
  task automatic t_guard;
    wr(2'h0, 32'h8001_0000, 0);
    ck(64'h0, 1, 0, 1, 0, 1);
    wr(2'h0, 32'h8000_0000, 0);
    ck(64'h0, 1, 0, 1, 0, 0);
    ck(64'h0, 1, 1, 1, 0, 1);
  endtask
  // modifiers under legacy and wide paging; paging is on from the guard test
  task automatic t_mods;
    ckx(1, 0, 1, 1, 0, 0, 0, 8'h20);
    wr(2'h1, 32'h0010_0090, 0);
    wr(2'h2, 32'h0000_0800, 0);
    ckx(1, 0, 1, 1, 1, 1, 1, 8'h28);
    ckx(0, 0, 1, 0, 0, 1, 1, 8'h20);
    ckx(0, 0, 0, 1, 0, 0, 1, 8'h28);
    ckx(0, 1, 0, 0, 0, 0, 1, 8'h20);
    wr(2'h1, 32'h0010_00b0, 0);
    cmp("mode", 4'h4, mode_ff);
    ckx(0, 1, 0, 1, 1, 0, 1, PHYS);
    cmp("phys_w", PHYS, chk_phys_w_ff);
  endtask
  task automatic t_fq;
    fq(32'h0000_0001, 3, 32'h0002_2048, 32'h0002_2048);
    fq(32'h0000_0001, 2, 32'h0002_0000, 32'h0002_0000);
    fq(32'h0000_0007, 1, 32'h0000_0080, 32'h0000_0080);
    fq(32'h8000_0001, 3, 32'h2410_0000, 32'h2410_0000);
    fq(32'h8000_0008, 0, 32'h0000_ffff, {16'h0, 8'h30, PHYS});
  endtask
  task automatic finish_test;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // watchdog: the run needs under a hundred cycles
  initial begin
    #50000;
    err_count++;
    finish_test;
  end
  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    rstn = 1;
    t_modes;
    t_long;
    t_vt;
    t_guard;
    t_mods;
    t_fq;
    finish_test;
  end
endmodule // testbench
